// file: src/bpw_pkg.sv
// Package of constants and types for the buck switching-cycle control block.
//
// Behaviour
// - Overcurrent while high-side driven ends pulse immediately.
// - High side stays off until next cycle.
// - Count up on overcurrent cycle, down otherwise.
// - At seven, restart with seven soft-start cycles.
// - Both gate drives off during restart.
// - Counter decrements per completed soft-start cycle.
// - At zero, re-enable modulation, normal start.
// - Persisting overcurrent repeats the hiccup sequence.
// - Cycle starts on sync falling edge.
// - Applied sync clock replaces internal oscillator.
// - Sync held low runs internal oscillator.
// - Sync before ramp completes declares undervoltage.
// - Seven long-ramp cycles before undervoltage declared.
package bpw_pkg;

    // ------------------------------------------------------------
    // Counts and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 100_000_000;
    localparam int unsigned FAULT_LIMIT     = 7;
    localparam int unsigned UV_LIMIT        = 7;
    localparam int unsigned SS_CYCLES       = 7;
    localparam int unsigned OSC_PERIOD_NS   = 2000;
    localparam int unsigned OSC_CYCLES      = (OSC_PERIOD_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned SYNC_LOSS_NS    = 4000;
    localparam int unsigned SYNC_LOSS_CYC   = (SYNC_LOSS_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam int unsigned SS_CYCLE_NS     = 20000;
    localparam int unsigned SS_CYCLE_CYC    = (SS_CYCLE_NS * (CLK_HZ / 1_000_000)) / 1000;

    localparam logic [2:0]  CNT_ZERO        = 3'h0;
    localparam logic [2:0]  CNT_FULL        = 3'(FAULT_LIMIT);
    localparam logic [2:0]  UV_FULL         = 3'(UV_LIMIT);
    localparam logic [2:0]  SS_FULL         = 3'(SS_CYCLES);
    localparam logic [15:0] OSC_TOP         = 16'(OSC_CYCLES - 1);
    localparam logic [15:0] SYNC_LOSS_TOP   = 16'(SYNC_LOSS_CYC - 1);
    localparam logic [15:0] SS_TOP          = 16'(SS_CYCLE_CYC - 1);

    typedef enum logic [1:0] {
        BPW_RUN     = 2'b00,
        BPW_HICCUP  = 2'b01,
        BPW_LOCKOUT = 2'b10
    } bpw_mode_e;

    typedef struct packed {
        logic       sync_m;
        logic       sync_s;
        logic       sync_d;
        logic       oc_m;
        logic       oc_s;
        logic       ramp_m;
        logic       ramp_s;
        logic       ext_sel;
        logic [15:0] osc_cnt;
        logic [15:0] loss_cnt;
        logic [15:0] ss_cnt;
        logic       oc_cycle;
        logic       hs_block;
        logic [2:0] fault_cnt;
        logic [2:0] uv_cnt;
        bpw_mode_e  mode;
        logic       hs_gate;
        logic       ls_gate;
        logic       cycle_start;
        logic       uv_flag;
        logic       hiccup;
    } bpw_state_s;

endpackage : bpw_pkg

// file: src/bpw_ctrl.sv
// Switching-cycle controller: cycle clock select, pulse-by-pulse limit, hiccup and undervoltage.
`timescale 1ns/1ns
`default_nettype none
module bpw_ctrl
    import bpw_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic resetn,
    input  wire logic sync_pin,
    input  wire logic current_limit_sense_pin,
    input  wire logic feedforward_ramp_pin,
    input  wire logic pwm_demand,
    output var  logic hs_gate,
    output var  logic ls_gate,
    output var  logic cycle_start,
    output var  logic undervoltage_lockout,
    output var  logic hiccup_active,
    output var  logic ext_clock_active,
    output var  logic [2:0] fault_count
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    bpw_state_s r;
    bpw_state_s next_r;

    logic sync_fall;
    logic start;
    logic osc_tick;

    always_comb begin
        next_r = r;
        // Pins cross in through two flops; sync_pin has a third, and its edge detect compares stages two and three.
        next_r.sync_m = sync_pin;
        next_r.sync_s = r.sync_m;
        next_r.sync_d = r.sync_s;
        next_r.oc_m   = current_limit_sense_pin;
        next_r.oc_s   = r.oc_m;
        next_r.ramp_m = feedforward_ramp_pin;
        next_r.ramp_s = r.ramp_m;

        sync_fall = r.sync_d & ~r.sync_s;
        osc_tick  = (r.osc_cnt == OSC_TOP);

        // ------------------------------------------------------------
        // Clock source select
        // ------------------------------------------------------------
        // Any falling edge hands cycle timing to the sync pin; a pin held low
        // for longer than the loss window falls back to the oscillator.
        if (sync_fall) begin
            next_r.ext_sel  = 1'b1;
            next_r.loss_cnt = 16'h0000;
        end else if (r.loss_cnt == SYNC_LOSS_TOP) begin
            next_r.ext_sel  = 1'b0;
        end else begin
            next_r.loss_cnt = r.loss_cnt + 16'h0001;
        end

        next_r.osc_cnt = osc_tick ? 16'h0000 : r.osc_cnt + 16'h0001;
        start = r.ext_sel ? sync_fall : (osc_tick & ~sync_fall);
        if (!r.ext_sel && sync_fall) begin
            start = 1'b1;
        end
        next_r.cycle_start = start;

        // ------------------------------------------------------------
        // Pulse-by-pulse limit
        // ------------------------------------------------------------
        if (r.hs_gate && r.oc_s) begin
            next_r.hs_block = 1'b1;
            next_r.oc_cycle = 1'b1;
        end
        if (start) begin
            next_r.hs_block = 1'b0;
            next_r.oc_cycle = 1'b0;
        end

        // ------------------------------------------------------------
        // Fault counter and modes
        // ------------------------------------------------------------
        next_r.ss_cnt = r.ss_cnt;
        unique case (r.mode)
            BPW_RUN: begin
                if (start) begin
                    if (r.oc_cycle) begin
                        if (r.fault_cnt == CNT_FULL - 3'h1) begin
                            next_r.mode    = BPW_HICCUP;
                            next_r.ss_cnt  = 16'h0000;
                        end
                        next_r.fault_cnt = r.fault_cnt + 3'h1;
                    end else if (r.fault_cnt != CNT_ZERO) begin
                        next_r.fault_cnt = r.fault_cnt - 3'h1;
                    end
                    // A ramp not finished when the cycle starts was interrupted. A run of
                    // seven is needed so that one line spike cannot shut the stage down.
                    if (!r.ramp_s) begin
                        if (r.uv_cnt == UV_FULL - 3'h1) begin
                            next_r.mode   = BPW_LOCKOUT;
                            next_r.uv_cnt = CNT_ZERO;
                        end else begin
                            next_r.uv_cnt = r.uv_cnt + 3'h1;
                        end
                    end else begin
                        next_r.uv_cnt = CNT_ZERO;
                    end
                end
            end
            BPW_HICCUP: begin
                // Soft-start cycles are timed from the system clock so a stuck
                // cycle clock cannot freeze the restart.
                if (r.ss_cnt == SS_TOP) begin
                    next_r.ss_cnt = 16'h0000;
                    next_r.fault_cnt = r.fault_cnt - 3'h1;
                    if (r.fault_cnt == 3'h1) begin
                        next_r.mode = BPW_RUN;
                    end
                end else begin
                    next_r.ss_cnt = r.ss_cnt + 16'h0001;
                end
            end
            BPW_LOCKOUT: begin
                // Seven good ramps in a row are needed to leave lockout.
                if (start) begin
                    if (r.ramp_s) begin
                        next_r.uv_cnt = r.uv_cnt + 3'h1;
                        if (r.uv_cnt == UV_FULL - 3'h1) begin
                            next_r.mode      = BPW_RUN;
                            next_r.fault_cnt = CNT_ZERO;
                            next_r.uv_cnt    = CNT_ZERO;
                        end
                    end else begin
                        next_r.uv_cnt = CNT_ZERO;
                    end
                end
            end
            default: begin
                next_r.mode = BPW_LOCKOUT;
            end
        endcase

        // ------------------------------------------------------------
        // Gate drives
        // ------------------------------------------------------------
        if (next_r.mode != BPW_RUN) begin
            next_r.hs_gate = 1'b0;
            next_r.ls_gate = 1'b0;
        end else begin
            next_r.hs_gate = pwm_demand & ~next_r.hs_block & ~(r.hs_gate & r.oc_s);
            next_r.ls_gate = ~next_r.hs_gate & ~r.hs_gate;
        end
        next_r.uv_flag = (next_r.mode == BPW_LOCKOUT);
        next_r.hiccup  = (next_r.mode == BPW_HICCUP);
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            r           <= '0;
            r.mode      <= BPW_LOCKOUT;
            r.uv_flag   <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign hs_gate              = r.hs_gate;
    assign ls_gate              = r.ls_gate;
    assign cycle_start          = r.cycle_start;
    assign undervoltage_lockout = r.uv_flag;
    assign hiccup_active        = r.hiccup;
    assign ext_clock_active     = r.ext_sel;
    assign fault_count          = r.fault_cnt;

endmodule // bpw_ctrl
`default_nettype wire

// file: sim/bpw_ctrl_chk.sv
// Checker for the switching-cycle control block.
`timescale 1ns/1ns
`default_nettype none
module bpw_ctrl_chk
    import bpw_pkg::*;
(
    input wire logic       clk_sys,
    input wire logic       resetn,
    input wire logic       sync_pin,
    input wire logic       current_limit_sense_pin,
    input wire logic       feedforward_ramp_pin,
    input wire logic       pwm_demand,
    input wire logic       hs_gate,
    input wire logic       ls_gate,
    input wire logic       cycle_start,
    input wire logic       undervoltage_lockout,
    input wire logic       hiccup_active,
    input wire logic       ext_clock_active,
    input wire logic [2:0] fault_count
);
    logic [1:0]  oc;
    logic [2:0]  sy;
    logic [2:0]  fc_q;
    logic [11:0] gap;
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            {oc, sy, fc_q, gap} <= '0;
        end else begin
            oc <= {oc[0], current_limit_sense_pin};
            sy <= {sy[1:0], sync_pin};
            fc_q <= fault_count;
            gap <= (fault_count != fc_q) ? 12'h000 : gap + 12'h001;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    hiccup_off_a: assert property (hiccup_active |-> !hs_gate && !ls_gate) else $error("gate on in restart");
    hiccup_full_a: assert property ($rose(hiccup_active) |-> fault_count == 3'h7) else $error("restart early");
    run_step_a: assert property (fault_count != fc_q && !hiccup_active && !$past(hiccup_active)
        && !undervoltage_lockout && !$past(undervoltage_lockout)
        |-> fault_count == fc_q + 3'h1 || fault_count == fc_q - 3'h1) else $error("count jump");
    ss_space_a: assert property (hiccup_active && $past(hiccup_active) && fault_count != fc_q
        |-> gap >= 12'h7CD && gap <= 12'h7D1) else $error("soft-start spacing");
    resume_zero_a: assert property ($fell(hiccup_active) |-> fault_count == 3'h0) else $error("resume not zero");
    sat_zero_a: assert property (fc_q == 3'h0 |-> fault_count != 3'h7) else $error("count wrapped");
    oc_hold_a: assert property (hs_gate && oc[1] |=> !hs_gate until cycle_start) else $error("pulse not cut");
    sync_edge_a: assert property (ext_clock_active && sy[2] && !sy[1] |-> ##[1:3] cycle_start)
        else $error("no start on sync fall");
endmodule // bpw_ctrl_chk
bind bpw_ctrl bpw_ctrl_chk chk_u (.*);
`default_nettype wire

// file: sim/bpw_sync_src.sv
// Model of the board clock source on the sync pin.
`timescale 1ns/1ns
`default_nettype none
module bpw_sync_src #(parameter int PER_NS = 1600) (
    input  wire logic en,
    output var  logic sync_pin
);
    // Held low while idle, so the block falls back to its own oscillator.
    initial sync_pin = 1'b0;
    always begin
        if (en) begin
            #(PER_NS / 2) sync_pin = 1'b1;
            #(PER_NS / 2) sync_pin = 1'b0;
        end else begin
            #3;
        end
    end
endmodule // bpw_sync_src
`default_nettype wire

// file: sim/bpw_ctrl_tb.sv
// Self-checking bench for the switching-cycle control block.
`timescale 1ns/1ns
`default_nettype none
module bpw_ctrl_tb;
    import bpw_pkg::*;
    localparam int PER_NS = 1600;
    logic clk_sys = 1'b0, resetn = 1'b0, oc = 1'b0, ramp = 1'b1, en = 1'b0;
    logic sync_pin, hs_gate, ls_gate, cycle_start, lockout, hic, ext;
    logic [2:0] fault_count;
    int failures = 0, compares = 0, n;
    always #5 clk_sys = ~clk_sys;
    bpw_sync_src #(.PER_NS(PER_NS)) src_u (.en(en), .sync_pin(sync_pin));
    bpw_ctrl dut_u (.clk_sys(clk_sys), .resetn(resetn), .sync_pin(sync_pin), .current_limit_sense_pin(oc),
        .feedforward_ramp_pin(ramp), .pwm_demand(1'b1), .hs_gate(hs_gate), .ls_gate(ls_gate),
        .cycle_start(cycle_start), .undervoltage_lockout(lockout), .hiccup_active(hic),
        .ext_clock_active(ext), .fault_count(fault_count));
    function automatic logic pick(input int k);
        case (k)
            0: return hic;
            1: return lockout;
            2: return ext;
            3: return hs_gate;
            default: return cycle_start;
        endcase
    endfunction
    task automatic chk(input logic c, input string m);
        compares++;
        if (!c) begin
            failures++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic wt(input int k, input logic v, input int lim);
        n = 0;
        while (pick(k) !== v && n < lim) begin
            @(negedge clk_sys);
            n++;
        end
        chk(n < lim, "wait ran out");
    endtask
    task automatic per();
        wt(4, 1'b1, 500);
        @(negedge clk_sys);
        wt(4, 1'b1, 500);
        n++;
    endtask
    task automatic t_start();
        wt(1, 1'b0, 3000);
        chk(fault_count === 3'h0 && ext === 1'b0, "start state");
        per();
        chk(n == OSC_CYCLES, "internal period");
    endtask
    task automatic t_hiccup();
        oc = 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(hs_gate === 1'b0, "pulse not cut");
        wt(0, 1'b1, 2000);
        chk(fault_count === 3'h7 && hs_gate === 1'b0 && ls_gate === 1'b0, "restart entry");
        wt(0, 1'b0, 16000);
        chk(n >= SS_CYCLES * SS_CYCLE_CYC - 3 && n <= SS_CYCLES * SS_CYCLE_CYC + 3, "restart length");
        chk(fault_count === 3'h0, "restart exit");
        wt(0, 1'b1, 2000);
        oc = 1'b0;
        wt(0, 1'b0, 16000);
        wt(3, 1'b1, 500);
        repeat (5) per();
        chk(fault_count === 3'h0, "count below zero");
    endtask
    task automatic t_ext();
        en = 1'b1;
        wt(2, 1'b1, 1000);
        per();
        chk(n >= PER_NS / 10 - 1 && n <= PER_NS / 10 + 1, "sync period");
        ramp = 1'b0;
        wt(1, 1'b1, 1500);
        wt(3, 1'b0, 10);
        en = 1'b0;
        wt(2, 1'b0, 1000);
        ramp = 1'b1;
        wt(1, 1'b0, 3000);
    endtask
    task automatic final_report();
        $display("Checks %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // The run needs about 40000 cycles; the watchdog allows half as much again.
    initial begin
        #600000;
        failures++;
        final_report();
    end
    initial begin
        repeat (16) @(negedge clk_sys);
        chk(lockout === 1'b1 && hs_gate === 1'b0, "reset state");
        resetn = 1'b1;
        t_start();
        t_hiccup();
        t_ext();
        final_report();
    end
endmodule // bpw_ctrl_tb
`default_nettype wire
